// [src/pidr_map.svh]
// Purpose: Constants of the identification query responder
// Assumes: Included by its bare name
// Notes:   Descriptor and field constants only
`ifndef PIDR_MAP_SVH
`define PIDR_MAP_SVH
`define PIDR_LEAF_VENDOR  32'h0000_0000
`define PIDR_LEAF_VERSION 32'h0000_0001
`define PIDR_LEAF_CACHE   32'h0000_0002
`define PIDR_MAX_LEAF     32'h0000_0002
`define PIDR_ZERO_WORD    32'h0000_0000
`define PIDR_UNDEF_WORD   32'h0000_0000
`define PIDR_CACHE_A      32'h0302_0101
`define PIDR_CACHE_D      32'h0604_0A42
`define PIDR_CACHE_BC     32'h0000_0000
`define PIDR_REPEAT_COUNT 8'h01
`define PIDR_BIT_FPU      0
`define PIDR_BIT_MCE      7
`define PIDR_BIT_CX8      8
`define PIDR_BIT_ONCHIP_INTERRUPT_CTRL_FEATURE     9
`define PIDR_BIT_MEMORY_TYPE_RANGES     12
`define PIDR_BIT_PGE      13
`define PIDR_BIT_MCA      14
`define PIDR_BIT_CONDITIONAL_MOVE_FEATURE     15
`define PIDR_LOW_MASK     32'h0000_007F
`define PIDR_VALID_BIT    31
`endif

// [src/pidr_pkg.sv]
// Purpose: Types of the identification query responder
// Assumes: Nothing
// Notes:   Holds the answer state type
package pidr_pkg;
  typedef enum logic [1:0] {PIDR_IDLE, PIDR_ANSWER} pidr_state_t;
endpackage

// [src/pidr_responder.sv]
// Summary of operation
// - Leaf 0 gives max leaf and vendor
// - Feature flag set exactly when supported
// - Bit 7 machine fault trap enable support
// - Bit 8 eight byte compare swap
// - Bit 9 only when interrupt controller usable
// - Bit 12 memory type range registers
// - Bit 13 global page enable support
// - Bit 14 fault global capability register
// - Bit 15 conditional move, float forms too
// - Leaf 2 low byte gives query count
// - That count is one
// - Leaf 2 bit 31 zero when valid
// - Valid leaf 2 words hold byte descriptors
// - Codes 01H, 02H instruction translation buffers
// - Codes 03H, 04H data translation buffers
// - Codes 06H, 0AH level one caches
// - Codes 41H to 43H unified caches
// - 00H null; words B, C nulls
// - Leaf 2 fixed words A and D
// - Leaf above maximum gives undefined words
// - Query serialises; waits for drain
//
// Purpose: Answers identification queries in four result words
// Assumes: Query pulse with leaf; pipeline drained flag from core
// Notes:   Undefined leaves answer zero words
`timescale 1ns/1ps
`include "pidr_map.svh"
module pidr_responder (
  input  wire logic        I_CLOCK,
  input  wire logic        I_NRST,
  input  wire logic        I_QUERY,
  input  wire logic [31:0] I_LEAF,
  input  wire logic        I_PIPE_DRAINED,
  input  wire logic [31:0] I_VENDOR_B,
  input  wire logic [31:0] I_VENDOR_C,
  input  wire logic [31:0] I_VENDOR_D,
  input  wire logic [3:0]  I_STEPPING,
  input  wire logic [3:0]  I_MODEL,
  input  wire logic [3:0]  I_FAMILY,
  input  wire logic [1:0]  I_PROC_TYPE,
  input  wire logic [6:0]  I_LOW_FEATURES,
  input  wire logic        I_MACHINE_FAULT_TRAP_FEATURE,
  input  wire logic        I_WIDE_SWAP_FEATURE,
  input  wire logic        I_INTR_CTRL_PRESENT,
  input  wire logic        I_INTR_CTRL_ENABLED,
  input  wire logic        I_MEMORY_TYPE_RANGES,
  input  wire logic        I_GLOBAL_PAGE_FEATURE,
  input  wire logic        I_MACHINE_FAULT_ARCH_FEATURE,
  input  wire logic        I_CONDITIONAL_MOVE_FEATURE,
  output logic             O_BUSY,
  output logic             O_DONE,
  output logic [31:0]      O_RESULT_WORD_A,
  output logic [31:0]      O_RESULT_WORD_B,
  output logic [31:0]      O_RESULT_WORD_C,
  output logic [31:0]      O_RESULT_WORD_D
);

  pidr_pkg::pidr_state_t state;
  pidr_pkg::pidr_state_t next_state;
  logic [31:0]           leaf;
  logic [31:0]           next_a;
  logic [31:0]           next_b;
  logic [31:0]           next_c;
  logic [31:0]           next_d;
  logic [31:0]           feature_word;
  logic [31:0]           version_word;
  logic [31:0]           cache_a;
  logic [31:0]           cache_desc;
  wire                   take;
  wire                   answer;

  // Leaf 2 word valid when bit 31 clear
  function automatic logic word_valid(input logic [31:0] w);
    word_valid = ~w[`PIDR_VALID_BIT];
  endfunction

  // Version fields; upper bits reserved as zero
  assign version_word = {18'h0_0000, I_PROC_TYPE, I_FAMILY, I_MODEL,
                         I_STEPPING};

  // Feature word; reserved bits zero
  assign feature_word = {16'h0000,
    I_CONDITIONAL_MOVE_FEATURE,
    I_MACHINE_FAULT_ARCH_FEATURE,
    I_GLOBAL_PAGE_FEATURE,
    I_MEMORY_TYPE_RANGES,
    2'b00,
    I_INTR_CTRL_PRESENT & I_INTR_CTRL_ENABLED,
    I_WIDE_SWAP_FEATURE,
    I_MACHINE_FAULT_TRAP_FEATURE,
    I_LOW_FEATURES};

  // Count byte and descriptors 01H 02H 03H
  assign cache_desc = `PIDR_CACHE_A;
  assign cache_a    = {cache_desc[31:8], `PIDR_REPEAT_COUNT};

  // Serialise: answer only once earlier work has drained
  assign take   = (state == pidr_pkg::PIDR_IDLE) & I_QUERY;
  assign answer = (state == pidr_pkg::PIDR_ANSWER) & I_PIPE_DRAINED;

  always_comb begin
    next_state = state;
    case (state)
      pidr_pkg::PIDR_IDLE: begin
        if (take) begin
          next_state = pidr_pkg::PIDR_ANSWER;
        end
      end
      pidr_pkg::PIDR_ANSWER: begin
        if (answer) begin
          next_state = pidr_pkg::PIDR_IDLE;
        end
      end
      default: begin
        next_state = pidr_pkg::PIDR_IDLE;
      end
    endcase
  end

  always_comb begin
    case (leaf)
      `PIDR_LEAF_VENDOR: begin
        next_a = `PIDR_MAX_LEAF;
        next_b = I_VENDOR_B;
        next_c = I_VENDOR_C;
        next_d = I_VENDOR_D;
      end
      `PIDR_LEAF_VERSION: begin
        next_a = version_word;
        next_b = `PIDR_ZERO_WORD;
        next_c = `PIDR_ZERO_WORD;
        next_d = feature_word;
      end
      `PIDR_LEAF_CACHE: begin
        // Byte descriptors, 06H 04H 0AH 42H in D
        next_a = cache_a;
        next_b = `PIDR_CACHE_BC;
        next_c = `PIDR_CACHE_BC;
        next_d = `PIDR_CACHE_D;
      end
      default: begin
        next_a = `PIDR_UNDEF_WORD;
        next_b = `PIDR_UNDEF_WORD;
        next_c = `PIDR_UNDEF_WORD;
        next_d = `PIDR_UNDEF_WORD;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      state <= pidr_pkg::PIDR_IDLE;
      leaf  <= `PIDR_ZERO_WORD;
    end else begin
      state <= next_state;
      if (take) begin
        leaf <= I_LEAF;
      end
    end
  end

  // Busy, done and result words; no fault output exists
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_BUSY          <= 1'b0;
      O_DONE          <= 1'b0;
      O_RESULT_WORD_A <= `PIDR_ZERO_WORD;
      O_RESULT_WORD_B <= `PIDR_ZERO_WORD;
      O_RESULT_WORD_C <= `PIDR_ZERO_WORD;
      O_RESULT_WORD_D <= `PIDR_ZERO_WORD;
    end else begin
      O_BUSY <= (next_state == pidr_pkg::PIDR_ANSWER);
      O_DONE <= answer;
      if (answer) begin
        O_RESULT_WORD_A <= next_a;
        O_RESULT_WORD_B <= next_b;
        O_RESULT_WORD_C <= next_c;
        O_RESULT_WORD_D <= next_d;
      end
    end
  end

  logic [31:0] last_leaf;
  always_ff @(posedge I_CLOCK or negedge I_NRST) begin
    if (!I_NRST) begin
      last_leaf <= `PIDR_ZERO_WORD;
    end else if (answer) begin
      last_leaf <= leaf;
    end
  end

  // Steps of one query: taken, held back or drained, one answer pulse
  sequence query_taken_s;
    take;
  endsequence
  sequence drained_s;
    I_PIPE_DRAINED;
  endsequence
  sequence held_back_s;
    !I_PIPE_DRAINED;
  endsequence
  sequence done_pulse_s;
    O_DONE ##1 !O_DONE;
  endsequence

  leaf0_max_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE && last_leaf == `PIDR_LEAF_VENDOR
      |-> O_RESULT_WORD_A == `PIDR_MAX_LEAF)
    else $error("leaf 0 max leaf wrong");
  vendor_words_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE && last_leaf == `PIDR_LEAF_VENDOR
      |-> O_RESULT_WORD_B == $past(I_VENDOR_B)
          && O_RESULT_WORD_D == $past(I_VENDOR_D)
          && O_RESULT_WORD_C == $past(I_VENDOR_C))
    else $error("vendor words wrong");
  version_fields_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE && last_leaf == `PIDR_LEAF_VERSION
      |-> O_RESULT_WORD_A[3:0] == $past(I_STEPPING)
          && O_RESULT_WORD_A[7:4] == $past(I_MODEL)
          && O_RESULT_WORD_A[11:8] == $past(I_FAMILY))
    else $error("version fields wrong");
  proc_type_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE && last_leaf == `PIDR_LEAF_VERSION
      |-> O_RESULT_WORD_A[13:12] == $past(I_PROC_TYPE)
          && O_RESULT_WORD_A[31:14] == 18'h0_0000
          && O_RESULT_WORD_B == `PIDR_ZERO_WORD
          && O_RESULT_WORD_C == `PIDR_ZERO_WORD)
    else $error("type field or reserved words wrong");
  feature_reserved_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE && last_leaf == `PIDR_LEAF_VERSION
      |-> O_RESULT_WORD_D[31:16] == 16'h0000
          && O_RESULT_WORD_D[11:10] == 2'b00)
    else $error("reserved feature bits set");
  trap_swap_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE && last_leaf == `PIDR_LEAF_VERSION
      |-> O_RESULT_WORD_D[`PIDR_BIT_MCE]
          == $past(I_MACHINE_FAULT_TRAP_FEATURE)
          && O_RESULT_WORD_D[`PIDR_BIT_CX8]
          == $past(I_WIDE_SWAP_FEATURE))
    else $error("trap or swap flag wrong");
  intr_ctrl_flag_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE && last_leaf == `PIDR_LEAF_VERSION
      |-> O_RESULT_WORD_D[`PIDR_BIT_ONCHIP_INTERRUPT_CTRL_FEATURE]
          == $past(I_INTR_CTRL_PRESENT & I_INTR_CTRL_ENABLED))
    else $error("interrupt controller flag wrong");
  page_range_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE && last_leaf == `PIDR_LEAF_VERSION
      |-> O_RESULT_WORD_D[`PIDR_BIT_MEMORY_TYPE_RANGES]
          == $past(I_MEMORY_TYPE_RANGES)
          && O_RESULT_WORD_D[`PIDR_BIT_PGE]
          == $past(I_GLOBAL_PAGE_FEATURE))
    else $error("range or global page flag wrong");
  arch_move_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE && last_leaf == `PIDR_LEAF_VERSION
      |-> O_RESULT_WORD_D[`PIDR_BIT_MCA]
          == $past(I_MACHINE_FAULT_ARCH_FEATURE)
          && O_RESULT_WORD_D[`PIDR_BIT_CONDITIONAL_MOVE_FEATURE]
          == $past(I_CONDITIONAL_MOVE_FEATURE)
          && O_RESULT_WORD_D[`PIDR_BIT_FPU]
          == $past(I_LOW_FEATURES[`PIDR_BIT_FPU]))
    else $error("fault arch or move flag wrong");
  repeat_count_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE && last_leaf == `PIDR_LEAF_CACHE
      |-> O_RESULT_WORD_A[7:0] == `PIDR_REPEAT_COUNT)
    else $error("repeat count not one");
  cache_valid_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE && last_leaf == `PIDR_LEAF_CACHE
      |-> word_valid(O_RESULT_WORD_A) && word_valid(O_RESULT_WORD_D)
          && word_valid(O_RESULT_WORD_B) && word_valid(O_RESULT_WORD_C))
    else $error("cache word marked reserved");
  cache_words_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE && last_leaf == `PIDR_LEAF_CACHE
      |-> O_RESULT_WORD_A == `PIDR_CACHE_A
          && O_RESULT_WORD_D == `PIDR_CACHE_D
          && O_RESULT_WORD_C == `PIDR_CACHE_BC)
    else $error("cache words wrong");
  cache_null_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE && last_leaf == `PIDR_LEAF_CACHE
      |-> O_RESULT_WORD_B == `PIDR_CACHE_BC
          && O_RESULT_WORD_C == `PIDR_CACHE_BC)
    else $error("null descriptor words wrong");
  undef_words_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE && last_leaf > `PIDR_MAX_LEAF
      |-> O_RESULT_WORD_A == `PIDR_UNDEF_WORD
          && O_RESULT_WORD_B == `PIDR_UNDEF_WORD
          && O_RESULT_WORD_C == `PIDR_UNDEF_WORD
          && O_RESULT_WORD_D == `PIDR_UNDEF_WORD)
    else $error("undefined leaf words wrong");
  serialise_wait_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    query_taken_s ##1 held_back_s |=> !O_DONE)
    else $error("answer before drain");
  answer_once_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    query_taken_s ##1 drained_s |=> done_pulse_s)
    else $error("answer timing wrong");
  busy_window_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    query_taken_s |=> O_BUSY)
    else $error("busy not raised after query");
  busy_clear_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    O_DONE |-> !O_BUSY)
    else $error("busy still high with answer");
  result_hold_a: assert property (
    @(posedge I_CLOCK) disable iff (!I_NRST)
    $changed(O_RESULT_WORD_A) || $changed(O_RESULT_WORD_B)
      || $changed(O_RESULT_WORD_C) || $changed(O_RESULT_WORD_D)
      |-> O_DONE)
    else $error("result words changed without answer");

endmodule

// [verification/pidr_pipe_model.sv]
// Purpose: Far side pipeline; reports when earlier work has drained
// Assumes: Busy from the responder; hold set by the bench
// Notes:   Hold counts busy cycles before drained rises
`timescale 1ns/1ps
module pidr_pipe_model (
  input  wire logic       i_clk,
  input  wire logic       i_busy,
  input  wire logic [3:0] i_hold,
  output logic            o_drained
);
  logic [3:0] cnt     = 4'h0;
  logic       drained = 1'b1;
  assign o_drained = drained;
  // Slow drain keeps the answer back
  always @(negedge i_clk) begin
    if (!i_busy) cnt = 4'h0;
    else if (cnt != 4'hF) cnt = cnt + 4'h1;
    drained = !i_busy || (cnt >= i_hold);
  end
endmodule

// [verification/tb_top.sv]
// Purpose: Self-checking bench of the identification responder
// Assumes: Inputs change at the falling edge
// Notes:   Undefined leaves are expected as zero words
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0, nrst = 1'b0, q = 1'b0, drained, busy, done;
  logic [31:0] leaf = 32'h0, a, b, c, d;
  logic [31:0] vb = 32'h1111_2222, vc = 32'h3333_4444, vd = 32'h5555_6666;
  logic [3:0]  hold = 4'h0, stp = 4'h3, mdl = 4'h5, fam = 4'h9;
  logic [1:0]  typ = 2'h2;
  logic [6:0]  low = 7'h00;
  logic [7:0]  ft = 8'h00;
  logic        ie = 1'b0;
  int          bad_count = 0, n_compared = 0, n;
  always #25 clk = ~clk;
  pidr_responder pidr_responder_i (.I_CLOCK(clk), .I_NRST(nrst),
    .I_QUERY(q), .I_LEAF(leaf), .I_PIPE_DRAINED(drained),
    .I_VENDOR_B(vb), .I_VENDOR_C(vc), .I_VENDOR_D(vd), .I_STEPPING(stp),
    .I_MODEL(mdl), .I_FAMILY(fam), .I_PROC_TYPE(typ), .I_LOW_FEATURES(low),
    .I_MACHINE_FAULT_TRAP_FEATURE(ft[0]), .I_WIDE_SWAP_FEATURE(ft[1]),
    .I_INTR_CTRL_PRESENT(ft[2]), .I_INTR_CTRL_ENABLED(ie),
    .I_MEMORY_TYPE_RANGES(ft[3]), .I_GLOBAL_PAGE_FEATURE(ft[4]),
    .I_MACHINE_FAULT_ARCH_FEATURE(ft[5]),
    .I_CONDITIONAL_MOVE_FEATURE(ft[6]), .O_BUSY(busy), .O_DONE(done),
    .O_RESULT_WORD_A(a), .O_RESULT_WORD_B(b), .O_RESULT_WORD_C(c),
    .O_RESULT_WORD_D(d));
  pidr_pipe_model pidr_pipe_model_i (.i_clk(clk), .i_busy(busy),
    .i_hold(hold), .o_drained(drained));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("compared=%0d mismatches=%0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One query; a second request while busy must be ignored
  task query(input logic [31:0] l, input logic poke);
    @(negedge clk);
    q = 1'b1;
    leaf = l;
    @(negedge clk);
    q = poke;
    leaf = 32'h0;
    n = 0;
    chk({31'h0, busy}, 32'h1);
    while (done !== 1'b1 && n < 40) begin
      @(negedge clk);
      q = 1'b0;
      n++;
    end
    chk({31'h0, done}, 32'h1);
    chk({31'h0, busy}, 32'h0);
    @(negedge clk);
    chk({30'h0, busy, done}, 32'h0);
  endtask
  task t_vendor;
    query(32'h0, 1'b0);
    chk(a, 32'h0000_0002);
    chk(b, vb);
    chk(c, vc);
    chk(d, vd);
  endtask
  task t_version(input logic [7:0] f, input logic en, input logic [6:0] lo);
    @(negedge clk);
    ft = f;
    ie = en;
    low = lo;
    query(32'h1, 1'b0);
    chk(a, {18'h0, typ, fam, mdl, stp});
    chk(b | c, 32'h0);
    chk(d, {16'h0, f[6], f[5], f[4], f[3], 2'b00, f[2] & en, f[1], f[0],
      lo});
    chk({31'h0, d[9]}, {31'h0, f[2] & en});
  endtask
  task t_cache(input logic [3:0] h);
    hold = h;
    query(32'h2, 1'b1);
    chk(n, (h > 4'h1) ? {28'h0, h} : 32'h1);
    chk(a, 32'h0302_0101);
    chk({24'h0, a[7:0]}, 32'h0000_0001);
    chk({28'h0, a[31], b[31], c[31], d[31]}, 32'h0);
    chk(b | c, 32'h0);
    chk(d, 32'h0604_0A42);
    hold = 4'h0;
  endtask
  task t_undef(input logic [31:0] l);
    query(l, 1'b0);
    chk(a | b | c | d, 32'h0);
  endtask
  // Reset in mid-run clears the words, then a query still works
  task t_reset;
    @(negedge clk);
    nrst = 1'b0;
    @(negedge clk);
    chk(a | b | c | d, 32'h0);
    chk({30'h0, busy, done}, 32'h0);
    nrst = 1'b1;
    t_vendor;
  endtask
  initial begin
    #100000;
    bad_count++;
    stop_test;
  end
  initial begin
    repeat (16) @(negedge clk);
    chk(a | b | c | d, 32'h0);
    chk({30'h0, busy, done}, 32'h0);
    nrst = 1'b1;
    t_vendor;
    t_version(8'h7F, 1'b1, 7'h01);
    t_version(8'h55, 1'b0, 7'h7E);
    t_version(8'h2A, 1'b1, 7'h00);
    t_cache(4'h0);
    t_cache(4'h6);
    t_undef(32'h0000_0003);
    t_undef(32'hFFFF_FFFF);
    t_cache(4'h1);
    t_reset;
    stop_test;
  end
endmodule
